// [hw/add_and_exec.sv]
// execute unit for add-with-carry, and-literal and and-register
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - add-carry sums W, byte, carry; five flags
// - add-carry destination: W or memory byte
// - bank bit picks access bank (page 0 or f) or bank register
// - extended set, low f: indexed offset address
// - and-literal into W, only N and Z
// - and-register ANDs W with byte, N Z
// - and-register destination: W or memory byte
module add_and_exec
   import add_and_exec_pkg::*;
(
   // clock, reset, enable
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // instruction fetch
   input  wire logic        instrValid,
   input  wire logic [15:0] instrWord,
   output var  logic        instrReady,
   // data memory
   output var  mem_req_t    memReq,
   input  wire logic [7:0]  memRdData,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic        wb_ack_o,
   output var  logic [31:0] wb_dat_o
);

   phase_t      phase_r;
   phase_t      phase_nxt;
   op_t         op_r;
   logic [15:0] instr_r;
   logic [7:0]  wReg_r;
   logic [7:0]  res_r;
   flags_t      flags_r;
   flags_t      flagsPend_r;
   flags_t      flagsNxt;
   logic [3:0]  bank_r;
   logic [11:0] idxBase_r;
   logic        extEn_r;
   mem_req_t    memReq_r;
   logic        rdy_r;
   logic        ack_r;
   logic [31:0] rdData_r;
   function automatic op_t decodeOp(input logic [15:0] w);
      if (w[15:10] == OPC6_ADDC)
         return OP_ADDC;
      if (w[15:8] == OPC8_ANDL)
         return OP_ANDL;
      if (w[15:10] == OPC6_ANDW)
         return OP_ANDW;
      return OP_NONE;
   endfunction
   function automatic logic usesMem(input op_t op);
      return (op == OP_ADDC) || (op == OP_ANDW);
   endfunction
   function automatic logic [11:0] effAddr(input logic [15:0] w,
                                           input logic        ext,
                                           input logic [3:0]  bank,
                                           input logic [11:0] idx);
      logic [7:0] f;
      f = w[7:0];
      if (w[BANK_BIT])
         effAddr = {bank, f};
      else if (ext && f <= IDX_LIMIT)
         effAddr = idx + {4'h0, f};
      else if (f < ACC_SPLIT)
         effAddr = {ACC_LO_PAGE, f};
      else
         effAddr = {ACC_HI_PAGE, f};
   endfunction

   // datapath
   logic        take;
   logic        destMem;
   logic        commit;
   logic        wrW;
   logic [7:0]  opnd;
   logic [8:0]  sumAll;
   logic [4:0]  sumLo;
   logic [7:0]  andRes;
   logic [7:0]  resNxt;
   assign take    = ce & instrValid & rdy_r;
   assign destMem = instr_r[DEST_BIT];
   assign commit  = ce & (phase_r == PH_WRITE) & (op_r != OP_NONE);
   assign opnd    = (op_r == OP_ANDL) ? instr_r[7:0] : memRdData;
   assign sumAll  = {1'b0, wReg_r} + {1'b0, opnd}
                  + {8'h00, flags_r.c};
   assign sumLo   = {1'b0, wReg_r[3:0]} + {1'b0, opnd[3:0]}
                  + {4'h0, flags_r.c};
   assign andRes  = wReg_r & opnd;
   assign resNxt  = (op_r == OP_ADDC) ? sumAll[7:0] : andRes;
   assign wrW     = commit & ((op_r == OP_ANDL) | ~destMem);

   always_comb
   begin
      flagsNxt   = flags_r;
      flagsNxt.n = resNxt[7];
      flagsNxt.z = (resNxt == 8'h00);
      if (op_r == OP_ADDC)
      begin
         flagsNxt.c  = sumAll[8];
         flagsNxt.dc = sumLo[4];
         flagsNxt.ov = (wReg_r[7] == opnd[7]) && (sumAll[7] != wReg_r[7]);
      end
   end

   // phase sequence: decode, read, process, write
   always_comb
   begin
      case (phase_r)
         PH_IDLE:    phase_nxt = take ? PH_DECODE : PH_IDLE;
         PH_DECODE:  phase_nxt = PH_READ;
         PH_READ:    phase_nxt = PH_PROCESS;
         PH_PROCESS: phase_nxt = PH_WRITE;
         PH_WRITE:   phase_nxt = PH_IDLE;
         default:    phase_nxt = PH_IDLE;
      endcase
   end

   // wishbone decode
   logic        wbReq;
   logic        wbWr;
   logic        hitCtrl;
   logic        hitBank;
   logic        hitWreg;
   logic        hitStat;
   logic        hitIdxb;
   logic [31:0] rdMux;
   assign wbReq   = wb_cyc_i & wb_stb_i;
   assign wbWr    = ce & wbReq & wb_we_i & ack_r & wb_sel_i[0];
   assign hitCtrl = (wb_adr_i == OFS_CTRL);
   assign hitBank = (wb_adr_i == OFS_BANK);
   assign hitWreg = (wb_adr_i == OFS_WREG);
   assign hitStat = (wb_adr_i == OFS_STAT);
   assign hitIdxb = (wb_adr_i == OFS_IDXB);
   assign rdMux   = hitCtrl ? {31'h00000000, extEn_r} :
                    hitBank ? {28'h0000000, bank_r} :
                    hitWreg ? {24'h000000, wReg_r} :
                    hitStat ? {27'h0000000, flags_r} :
                    hitIdxb ? {20'h00000, idxBase_r} : 32'h00000000;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ack_r    <= 1'b0;
         rdData_r <= 32'h00000000;
      end
      else if (ce)
      begin
         ack_r <= wbReq & ~ack_r;
         if (wbReq & ~ack_r)
            rdData_r <= rdMux;
      end
   end

   // sequencing and instruction capture
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         phase_r <= PH_IDLE;
         rdy_r   <= 1'b1;
         op_r    <= OP_NONE;
         instr_r <= 16'h0000;
      end
      else if (ce)
      begin
         phase_r <= phase_nxt;
         rdy_r   <= (phase_nxt == PH_IDLE);
         if (take)
         begin
            op_r    <= decodeOp(instrWord);
            instr_r <= instrWord;
         end
      end
   end

   // memory request: read in read phase, write in write phase
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         memReq_r <= MEM_IDLE;
      else if (ce)
      begin
         case (phase_r)
            PH_DECODE:
               if (usesMem(op_r))
               begin
                  memReq_r.addr <= effAddr(instr_r, extEn_r, bank_r,
                                           idxBase_r);
                  memReq_r.rd   <= 1'b1;
               end
            PH_READ:
               memReq_r.rd <= 1'b0;
            PH_PROCESS:
               if (usesMem(op_r) && destMem)
               begin
                  memReq_r.we    <= 1'b1;
                  memReq_r.wdata <= resNxt;
               end
            PH_WRITE:
               memReq_r <= MEM_IDLE;
            default: ;
         endcase
      end
   end

   // result and pending flags, captured in process phase
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         res_r       <= RST_WREG;
         flagsPend_r <= RST_FLAGS;
      end
      else if (ce && phase_r == PH_PROCESS)
      begin
         res_r       <= resNxt;
         flagsPend_r <= flagsNxt;
      end
   end

   // architectural state; instruction commit wins over a bus write
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wReg_r    <= RST_WREG;
         flags_r   <= RST_FLAGS;
         bank_r    <= RST_BANK;
         idxBase_r <= RST_IDXB;
         extEn_r   <= RST_EXT;
      end
      else if (ce)
      begin
         if (wrW)
            wReg_r <= res_r;
         else if (wbWr && hitWreg)
            wReg_r <= wb_dat_i[7:0];
         if (commit)
            flags_r <= flagsPend_r;
         else if (wbWr && hitStat)
            flags_r <= flags_t'(wb_dat_i[4:0]);
         if (wbWr && hitBank)
            bank_r <= wb_dat_i[3:0];
         if (wbWr && hitIdxb)
            idxBase_r <= {wb_sel_i[1] ? wb_dat_i[11:8] : idxBase_r[11:8],
                          wb_dat_i[7:0]};
         if (wbWr && hitCtrl)
            extEn_r <= wb_dat_i[CTRL_EXT_BIT];
      end
   end

   assign instrReady = rdy_r;
   assign memReq     = memReq_r;
   assign wb_ack_o   = ack_r;
   assign wb_dat_o   = rdData_r;
   // checks
   logic [2:0] execCnt;
   always_ff @(posedge clk)
   begin
      if (!rst_n || phase_r == PH_IDLE)
         execCnt <= 3'h0;
      else if (ce)
         execCnt <= execCnt + 3'h1;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n || !ce);
   chk_addc_sum: assert property (
      (phase_r == PH_PROCESS && op_r == OP_ADDC) |=>
         res_r == 8'($past(wReg_r) + $past(memRdData)
                     + {7'h00, $past(flags_r.c)})
         && flagsPend_r.z == (res_r == 8'h00)
         && flagsPend_r.n == res_r[7])
      else $error("add-carry result or flags wrong");
   chk_addc_dest: assert property (
      (phase_r == PH_WRITE && op_r == OP_ADDC) |->
         (destMem && memReq_r.we && memReq_r.wdata == res_r)
         or (!destMem && !memReq_r.we ##1 wReg_r == $past(res_r)))
      else $error("add-carry destination wrong");
   chk_bank_addr: assert property (
      (phase_r == PH_READ && usesMem(op_r) && instr_r[BANK_BIT]) |->
         memReq_r.addr == {$past(bank_r), instr_r[7:0]} && memReq_r.rd)
      else $error("banked address wrong");
   chk_index_addr: assert property (
      (phase_r == PH_READ && usesMem(op_r) && !instr_r[BANK_BIT]
       && $past(extEn_r) && instr_r[7:0] <= IDX_LIMIT) |->
         memReq_r.addr == $past(idxBase_r) + {4'h0, instr_r[7:0]})
      else $error("indexed address wrong");
   chk_andl_flags: assert property (
      (phase_r == PH_WRITE && op_r == OP_ANDL) |=>
         wReg_r == ($past(wReg_r) & instr_r[7:0])
         && flags_r.c == $past(flags_r.c)
         && flags_r.ov == $past(flags_r.ov) && !memReq_r.we)
      else $error("and-literal wrong");
   chk_andw_result: assert property (
      (phase_r == PH_PROCESS && op_r == OP_ANDW) |=>
         res_r == ($past(wReg_r) & $past(memRdData))
         && flagsPend_r.dc == $past(flags_r.dc))
      else $error("and-register result wrong");
   chk_andw_dest: assert property (
      (phase_r == PH_WRITE && op_r == OP_ANDW && destMem) |->
         memReq_r.we && memReq_r.wdata == res_r
         && memReq_r.addr == $past(memReq_r.addr, 2))
      else $error("and-register write-back wrong");
   chk_one_cycle: assert property (
      take |=> (phase_r == PH_DECODE && !rdy_r) ##1 phase_r == PH_READ
         ##1 phase_r == PH_PROCESS
         ##1 (phase_r == PH_WRITE && execCnt == 3'(PHASE_CYCLES - 1))
         ##1 (phase_r == PH_IDLE && rdy_r))
      else $error("instruction exceeds four phases");

   cov_addc_mem: cover property (
      phase_r == PH_WRITE && op_r == OP_ADDC && destMem);
   cov_andl: cover property (phase_r == PH_WRITE && op_r == OP_ANDL);
   cov_index: cover property (
      phase_r == PH_READ && !instr_r[BANK_BIT] && extEn_r
      && instr_r[7:0] <= IDX_LIMIT);
   cov_andw_w: cover property (
      phase_r == PH_WRITE && op_r == OP_ANDW && !destMem);
endmodule

`default_nettype wire

// [hw/add_and_exec_pkg.sv]
// constants and carriers shared by the add/and execute unit
package add_and_exec_pkg;
   // opcode fields of the 16-bit instruction word
   localparam logic [5:0]  OPC6_ADDC    = 6'h08;
   localparam logic [5:0]  OPC6_ANDW    = 6'h05;
   localparam logic [7:0]  OPC8_ANDL    = 8'h0b;
   localparam int          DEST_BIT     = 9;
   localparam int          BANK_BIT     = 8;
   // access bank split and indexed window
   localparam logic [7:0]  ACC_SPLIT    = 8'h60;
   localparam logic [7:0]  IDX_LIMIT    = 8'h5f;
   localparam logic [3:0]  ACC_LO_PAGE  = 4'h0;
   localparam logic [3:0]  ACC_HI_PAGE  = 4'hf;
   // register byte offsets
   localparam logic [7:0]  OFS_CTRL     = 8'h00;
   localparam logic [7:0]  OFS_BANK     = 8'h04;
   localparam logic [7:0]  OFS_WREG     = 8'h08;
   localparam logic [7:0]  OFS_STAT     = 8'h0c;
   localparam logic [7:0]  OFS_IDXB     = 8'h10;
   localparam int          CTRL_EXT_BIT = 0;
   // values after reset
   localparam logic        RST_EXT      = 1'b0;
   localparam logic [3:0]  RST_BANK     = 4'h0;
   localparam logic [7:0]  RST_WREG     = 8'h00;
   localparam logic [11:0] RST_IDXB     = 12'h000;
   // clocks per instruction cycle
   localparam int          PHASE_CYCLES = 4;

   typedef enum {PH_IDLE, PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} phase_t;
   typedef enum {OP_NONE, OP_ADDC, OP_ANDL, OP_ANDW} op_t;

   typedef struct packed {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } flags_t;

   typedef struct packed {
      logic [11:0] addr;
      logic        rd;
      logic        we;
      logic [7:0]  wdata;
   } mem_req_t;

   localparam flags_t   RST_FLAGS = 5'h00;
   localparam mem_req_t MEM_IDLE  = 22'h000000;
endpackage

// [testbench/add_carry_and_logic_ops_bench.sv]
// self-checking bench for the add/and execute unit
`timescale 1ns/1ps
`default_nettype none
module add_carry_and_logic_ops_bench
   import add_and_exec_pkg::*;
;
   typedef struct {
      logic        ext;
      logic [15:0] ins;
      logic [7:0]  w, st, mv;
      logic [11:0] ad;
      logic        rd, wr;
      logic [7:0]  ew, es, ed;
   } row_t;

   logic        clk, rst_n, ce, instrValid, instrReady;
   logic [15:0] instrWord;
   mem_req_t    memReq;
   logic [7:0]  memRdData, wd;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rd, wr;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [11:0] ad;
   int          n_fail = 0;
   int          checked = 0;
   row_t        rows [8] = '{
      '{0, 16'h2120, 8'h4d, 8'h01, 8'h02, 12'h320, 1, 0, 8'h50, 8'h02, 8'h00},
      '{0, 16'h2270, 8'h7f, 8'h01, 8'h00, 12'hf70, 1, 1, 8'h7f, 8'h1a, 8'h80},
      '{0, 16'h2010, 8'hff, 8'h00, 8'h01, 12'h010, 1, 0, 8'h00, 8'h07, 8'h00},
      '{1, 16'h205f, 8'h80, 8'h00, 8'h80, 12'h25f, 1, 0, 8'h00, 8'h0d, 8'h00},
      '{1, 16'h1460, 8'ha3, 8'h1f, 8'h5f, 12'hf60, 1, 0, 8'h03, 8'h0b, 8'h00},
      '{0, 16'h0b5f, 8'ha3, 8'h04, 8'h00, 12'h000, 0, 0, 8'h03, 8'h00, 8'h00},
      '{0, 16'h0bf0, 8'h0f, 8'h1b, 8'h00, 12'h000, 0, 0, 8'h00, 8'h0f, 8'h00},
      '{1, 16'h17c2, 8'h80, 8'h00, 8'hf0, 12'h3c2, 1, 1, 8'h80, 8'h10, 8'h80}};

   add_and_exec uut (.clk(clk), .rst_n(rst_n), .ce(ce),
      .instrValid(instrValid), .instrWord(instrWord),
      .instrReady(instrReady), .memReq(memReq), .memRdData(memRdData),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o));

   data_mem_model mdl (.clk(clk), .memReq(memReq), .memRdData(memRdData));

   task automatic end_sim();
      if (n_fail == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one classic cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rq);
      int i;
      i = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_sel_i <= 4'hf;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
      begin
         @(posedge clk);
         i++;
      end
      while (wb_ack_o !== 1'b1 && i < 20);
      rq = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
      if (i >= 20)
      begin
         n_fail++;
         end_sim();
      end
   endtask

   // issue one word, watch memory traffic until idle again
   task automatic run(input logic [15:0] ins);
      int n;
      n = 0;
      rd = 1'b0;
      wr = 1'b0;
      instrValid <= 1'b1;
      instrWord <= ins;
      @(posedge clk);
      instrValid <= 1'b0;
      do
      begin
         @(posedge clk);
         n++;
         if (memReq.rd === 1'b1)
         begin
            rd = 1'b1;
            ad = memReq.addr;
         end
         if (memReq.we === 1'b1)
         begin
            wr = 1'b1;
            wd = memReq.wdata;
            ad = memReq.addr;
         end
      end
      while (instrReady !== 1'b1 && n < 20);
      chk("busy cycles", n - 1, 4);
      if (n >= 20)
      begin
         n_fail++;
         end_sim();
      end
   endtask

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial
   begin
      {rst_n, ce, instrValid, instrWord} = '0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
      wb_sel_i = 4'hf;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      ce <= 1'b1;
      @(posedge clk);
      wb(1'b0, OFS_WREG, 32'h0, q);
      chk("w after reset", q, 32'h0);
      wb(1'b0, OFS_STAT, 32'h0, q);
      chk("status after reset", q, 32'h0);
      wb(1'b1, 8'h14, 32'hff, q);
      wb(1'b0, 8'h14, 32'h0, q);
      chk("unmapped read", q, 32'h0);
      wb(1'b1, OFS_BANK, 32'h3, q);
      wb(1'b1, OFS_IDXB, 32'h200, q);
      foreach (rows[k])
      begin
         wb(1'b1, OFS_CTRL, {31'h0, rows[k].ext}, q);
         wb(1'b1, OFS_WREG, {24'h0, rows[k].w}, q);
         wb(1'b1, OFS_STAT, {24'h0, rows[k].st}, q);
         mdl.mem[rows[k].ad] = rows[k].mv;
         run(rows[k].ins);
         chk("read issued", rd, rows[k].rd);
         chk("write issued", wr, rows[k].wr);
         if (rows[k].rd)
            chk("address", ad, rows[k].ad);
         if (rows[k].wr)
            chk("written byte", wd, rows[k].ed);
         wb(1'b0, OFS_WREG, 32'h0, q);
         chk("w", q, rows[k].ew);
         wb(1'b0, OFS_STAT, 32'h0, q);
         chk("status", q, rows[k].es);
      end
      // unknown word: four phases, no memory traffic, state kept
      run(16'h0000);
      chk("unknown read", rd, 1'b0);
      chk("unknown write", wr, 1'b0);
      wb(1'b0, OFS_STAT, 32'h0, q);
      chk("status kept", q, 32'h10);
      wb(1'b0, OFS_BANK, 32'h0, q);
      chk("bank", q, 32'h3);
      wb(1'b0, OFS_IDXB, 32'h0, q);
      chk("index base", q, 32'h200);
      wb(1'b0, OFS_CTRL, 32'h0, q);
      chk("extended set", q, 32'h1);
      // clock enable low: offered word must not execute
      ce <= 1'b0;
      instrValid <= 1'b1;
      instrWord <= 16'h0b00;
      repeat (4) @(posedge clk);
      instrValid <= 1'b0;
      ce <= 1'b1;
      @(posedge clk);
      wb(1'b0, OFS_WREG, 32'h0, q);
      chk("w frozen", q, 32'h80);
      // reset in mid-run: every register back to its reset value
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("ready after reset", instrReady, 1'b1);
      chk("memory request after reset", memReq, MEM_IDLE);
      wb(1'b0, OFS_WREG, 32'h0, q);
      chk("w after mid reset", q, {24'h0, RST_WREG});
      wb(1'b0, OFS_STAT, 32'h0, q);
      chk("status after mid reset", q, {27'h0, RST_FLAGS});
      wb(1'b0, OFS_BANK, 32'h0, q);
      chk("bank after mid reset", q, {28'h0, RST_BANK});
      wb(1'b0, OFS_CTRL, 32'h0, q);
      chk("ext after mid reset", q, {31'h0, RST_EXT});
      wb(1'b0, OFS_IDXB, 32'h0, q);
      chk("base after mid reset", q, {20'h0, RST_IDXB});
      end_sim();
   end
endmodule
`default_nettype wire

// [testbench/data_mem_model.sv]
// data memory model answering one clock after a read request
`timescale 1ns/1ps
`default_nettype none
module data_mem_model
   import add_and_exec_pkg::*;
(
   // clock
   input  wire logic       clk,
   // request and answer
   input  wire mem_req_t   memReq,
   output var  logic [7:0] memRdData = 8'h5a
);
   logic [7:0] mem [0:4095];

   always @(posedge clk)
   begin
      // off read cycles the bus toggles, never holds stale data
      if (memReq.rd === 1'b1)
         memRdData <= mem[memReq.addr];
      else
         memRdData <= ~memRdData;
      if (memReq.we === 1'b1)
         mem[memReq.addr] <= memReq.wdata;
   end
endmodule
`default_nettype wire
